// ### src/bram_fifo.sv
// Block RAM with a random access port, a FIFO port and an Avalon-MM register slave.
`timescale 1ns/100ps
`include "bram_fifo_defines.svh"

module bram_fifo #(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 3,
  parameter int RAM_AW = 4,
  parameter bit PORT_A_ASYNC = 1'b0,
  parameter bit PORT_B_ASYNC = 1'b0
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [DATA_W-1:0] write_data,
  input wire logic write_clock_enable,
  input wire logic write_strobe,
  input wire logic read_clock_enable,
  input wire logic read_strobe,
  output logic [DATA_W-1:0] read_data,
  input wire logic fifo_clear,
  input wire logic read_pointer_rewind,
  input wire logic port_a_latch_clear,
  input wire logic port_b_latch_clear,
  input wire logic device_wide_clear_n,
  output logic full_flag,
  output logic near_full_flag,
  output logic near_empty_flag,
  output logic empty_flag
);
  localparam int CW = ADDR_W + 1;
  localparam int DEPTH = 1 << ADDR_W;

  generate
    if (DATA_W < 1 || DATA_W > 8 || ADDR_W != 3 || RAM_AW < 1 || RAM_AW > 8)
    begin : g_check
      $error("bram_fifo: DATA_W 1..8, ADDR_W 3 and RAM_AW 1..8 are served");
    end
  endgenerate

  // ****************************************************************
  // Declarations.
  // ****************************************************************
  fifo_store_if #(.WIDTH(DATA_W), .ADDR_W(ADDR_W)) fifo_link ();
  out_latch_if #(.WIDTH(DATA_W)) latch_a ();
  out_latch_if #(.WIDTH(DATA_W)) latch_b ();

  bram_fifo_pkg::bus_state_e state;
  bram_fifo_pkg::bus_state_e next_state;
  logic next_waitrequest;
  logic [31:0] next_readdata;
  bram_fifo_pkg::write_mode_e mode;
  bram_fifo_pkg::write_mode_e next_mode;
  logic [CW-1:0] full_thr;
  logic [CW-1:0] near_full_thr;
  logic [CW-1:0] near_empty_thr;
  logic [CW-1:0] next_full_thr;
  logic [CW-1:0] next_near_full_thr;
  logic [CW-1:0] next_near_empty_thr;
  logic [RAM_AW-1:0] ram_addr;
  logic [RAM_AW-1:0] next_ram_addr;
  logic [DATA_W-1:0] ram [1 << RAM_AW];
  logic take;
  logic lane0;
  logic soft_clear;
  logic soft_rewind;
  logic ram_we;
  logic ram_re;
  logic can_write;
  logic next_full;
  logic next_near_full;
  logic next_near_empty;
  logic next_empty;
  logic [CW-1:0] wthr;

  // A write takes effect on the edge where the master sees waitrequest low.
  assign take = write && state == bram_fifo_pkg::BUS_ANSWER;
  assign lane0 = byteenable[0];
  assign wthr = writedata[CW-1:0];

  // Threshold range check for the near thresholds against a full threshold.
  function automatic logic near_ok(input logic [CW-1:0] v, input logic [CW-1:0] full);
    near_ok = v >= CW'(1) && v < full;
  endfunction

  // Register read decode.
  function automatic logic [31:0] reg_value(input logic [5:0] a);
    reg_value = 32'h0000_0000;
    case (a)
      `REG_CTRL: reg_value[`CTRL_MODE_LSB +: 2] = mode;
      `REG_FULL_THR: reg_value[CW-1:0] = full_thr;
      `REG_NEAR_FULL_THR: reg_value[CW-1:0] = near_full_thr;
      `REG_NEAR_EMPTY_THR: reg_value[CW-1:0] = near_empty_thr;
      `REG_STATUS:
      begin
        reg_value[3:0] = {full_flag, near_full_flag, near_empty_flag, empty_flag};
        reg_value[`STATUS_COUNT_LSB +: CW] = fifo_link.count;
      end
      `REG_RAM_ADDR: reg_value[RAM_AW-1:0] = ram_addr;
      `REG_RAM_DATA: reg_value[DATA_W-1:0] = latch_a.q;
      default: reg_value = 32'h0000_0000;
    endcase
  endfunction

  // ****************************************************************
  // Avalon-MM slave handshake.
  // ****************************************************************

  // Answer one cycle after a request; waitrequest low for exactly one cycle.
  always_comb
  begin
    next_state = bram_fifo_pkg::BUS_IDLE;
    next_waitrequest = 1'b1;
    next_readdata = readdata;
    case (state)
      bram_fifo_pkg::BUS_IDLE:
      begin
        if (read || write)
        begin
          next_state = bram_fifo_pkg::BUS_ANSWER;
          next_waitrequest = 1'b0;
          next_readdata = read ? reg_value(address) : 32'h0000_0000;
        end
      end
      bram_fifo_pkg::BUS_ANSWER: next_state = bram_fifo_pkg::BUS_IDLE;
      default: next_state = bram_fifo_pkg::BUS_IDLE;
    endcase
  end

  // Handshake registers.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state <= bram_fifo_pkg::BUS_IDLE;
      waitrequest <= 1'b1;
      readdata <= 32'h0000_0000;
    end
    else
    begin
      state <= next_state;
      waitrequest <= next_waitrequest;
      readdata <= next_readdata;
    end
  end

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************

  // Out of range thresholds are refused and the old value kept.
  always_comb
  begin
    next_mode = mode;
    next_full_thr = full_thr;
    next_near_full_thr = near_full_thr;
    next_near_empty_thr = near_empty_thr;
    next_ram_addr = ram_addr;
    if (take && lane0)
    begin
      case (address)
        `REG_CTRL:
        begin
          if (writedata[`CTRL_MODE_LSB +: 2] != 2'h3)
          begin
            next_mode = bram_fifo_pkg::write_mode_e'(writedata[`CTRL_MODE_LSB +: 2]);
          end
        end
        `REG_FULL_THR:
        begin
          if (wthr >= CW'(1) && wthr <= CW'(DEPTH - 1) && wthr > near_full_thr
              && wthr > near_empty_thr)
          begin
            next_full_thr = wthr;
          end
        end
        `REG_NEAR_FULL_THR:
        begin
          if (near_ok(wthr, full_thr))
          begin
            next_near_full_thr = wthr;
          end
        end
        `REG_NEAR_EMPTY_THR:
        begin
          if (near_ok(wthr, full_thr))
          begin
            next_near_empty_thr = wthr;
          end
        end
        `REG_RAM_ADDR: next_ram_addr = writedata[RAM_AW-1:0];
        default: next_mode = mode;
      endcase
    end
  end

  // Configuration registers.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode <= bram_fifo_pkg::WRITE_NORMAL;
      full_thr <= CW'(`RST_FULL_THR);
      near_full_thr <= CW'(`RST_NEAR_FULL_THR);
      near_empty_thr <= CW'(`RST_NEAR_EMPTY_THR);
      ram_addr <= '0;
    end
    else
    begin
      mode <= next_mode;
      full_thr <= next_full_thr;
      near_full_thr <= next_near_full_thr;
      near_empty_thr <= next_near_empty_thr;
      ram_addr <= next_ram_addr;
    end
  end

  // ****************************************************************
  // Random access port A.
  // ****************************************************************
  assign ram_we = take && lane0 && address == `REG_RAM_DATA;
  assign ram_re = take && lane0 && address == `REG_RAM_CMD && writedata[`RAM_CMD_READ_BIT];

  // Port A latch load follows the write behaviour selected in CTRL.
  always_comb
  begin
    latch_a.load = ram_re;
    latch_a.d = ram[ram_addr];
    if (ram_we)
    begin
      case (mode)
        bram_fifo_pkg::WRITE_THROUGH:
        begin
          latch_a.load = 1'b1;
          latch_a.d = writedata[DATA_W-1:0];
        end
        bram_fifo_pkg::WRITE_READ_FIRST: latch_a.load = 1'b1;
        default: latch_a.load = 1'b0;
      endcase
    end
  end
  assign latch_a.local_clear = port_a_latch_clear;
  assign latch_a.global_clear_n = device_wide_clear_n;

  // RAM array write.
  always_ff @(posedge clk)
  begin
    if (ram_we)
    begin
      ram[ram_addr] <= writedata[DATA_W-1:0];
    end
  end

  out_latch #(.ASYNC_CLEAR(PORT_A_ASYNC)) u_latch_a (
    .clk(clk),
    .rst(rst),
    .lp(latch_a.latch)
  );

  // ****************************************************************
  // FIFO port B.
  // ****************************************************************
  assign soft_clear = take && lane0 && address == `REG_CTRL && writedata[`CTRL_CLEAR_BIT];
  assign soft_rewind = take && lane0 && address == `REG_CTRL && writedata[`CTRL_REWIND_BIT];
  assign can_write = fifo_link.count < full_thr;
  assign fifo_link.clear = fifo_clear | soft_clear;
  assign fifo_link.rewind = read_pointer_rewind | soft_rewind;
  assign fifo_link.in_valid = write_clock_enable & write_strobe & can_write;
  assign fifo_link.in_data = write_data;
  assign fifo_link.out_ready = read_clock_enable & read_strobe;
  assign latch_b.load = fifo_link.out_valid & fifo_link.out_ready;
  assign latch_b.d = fifo_link.out_data;
  assign latch_b.local_clear = port_b_latch_clear;
  assign latch_b.global_clear_n = device_wide_clear_n;
  assign read_data = latch_b.q;

  fifo_store #(.WIDTH(DATA_W), .ADDR_W(ADDR_W)) u_store (
    .clk(clk),
    .rst(rst),
    .fs(fifo_link.store)
  );

  out_latch #(.ASYNC_CLEAR(PORT_B_ASYNC)) u_latch_b (
    .clk(clk),
    .rst(rst),
    .lp(latch_b.latch)
  );

  // Flags from the occupancy; a clear forces the reset pattern.
  always_comb
  begin
    next_full = fifo_link.count >= full_thr;
    next_near_full = fifo_link.count >= near_full_thr;
    next_near_empty = fifo_link.count <= near_empty_thr;
    next_empty = fifo_link.count == CW'(`EMPTY_THR);
    if (fifo_link.clear)
    begin
      next_full = 1'b0;
      next_near_full = 1'b0;
      next_near_empty = 1'b1;
      next_empty = 1'b1;
    end
  end

  // Flag registers on the single clock that serves both FIFO sides.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      full_flag <= 1'b0;
      near_full_flag <= 1'b0;
      near_empty_flag <= 1'b1;
      empty_flag <= 1'b1;
    end
    else
    begin
      full_flag <= next_full;
      near_full_flag <= next_near_full;
      near_empty_flag <= next_near_empty;
      empty_flag <= next_empty;
    end
  end

  // ****************************************************************
  // Assertions and covers.
  // ****************************************************************
  a_bus_answer_once: assert property (@(posedge clk) disable iff (rst)
    (read || write) && state == bram_fifo_pkg::BUS_IDLE |=> !waitrequest ##1 waitrequest)
    else $error("waitrequest not low for exactly one cycle");
  a_normal_no_show: assert property (@(posedge clk) disable iff (rst)
    ram_we && mode == bram_fifo_pkg::WRITE_NORMAL && !port_a_latch_clear && device_wide_clear_n
    |=> $stable(latch_a.q))
    else $error("normal write changed port A output");
  a_write_through_copy: assert property (@(posedge clk) disable iff (rst)
    ram_we && mode == bram_fifo_pkg::WRITE_THROUGH && !port_a_latch_clear && device_wide_clear_n
    |=> latch_a.q == $past(writedata[DATA_W-1:0]))
    else $error("write-through copy missing");
  a_read_first_old: assert property (@(posedge clk) disable iff (rst)
    ram_we && mode == bram_fifo_pkg::WRITE_READ_FIRST && !port_a_latch_clear
    && device_wide_clear_n |=> latch_a.q == $past(ram[ram_addr]))
    else $error("read-before-write did not show old word");
  a_full_tracks_count: assert property (@(posedge clk) disable iff (rst)
    !fifo_link.clear |=> full_flag == ($past(fifo_link.count) >= $past(full_thr)))
    else $error("full flag does not follow occupancy");
  a_empty_tracks_count: assert property (@(posedge clk) disable iff (rst)
    !fifo_link.clear |=> empty_flag == ($past(fifo_link.count) == '0))
    else $error("empty flag does not follow occupancy");
  a_clear_flags: assert property (@(posedge clk) disable iff (rst)
    fifo_link.clear |=> empty_flag && near_empty_flag && !full_flag && !near_full_flag
    ##1 empty_flag)
    else $error("clear did not restore flags");
  a_port_a_local: assert property (@(posedge clk) disable iff (rst)
    port_a_latch_clear && !latch_b.load && !port_b_latch_clear && device_wide_clear_n
    && !PORT_A_ASYNC
    |=> latch_a.q == '0 && $stable(latch_b.q))
    else $error("port A clear not local");
  a_global_clear: assert property (@(posedge clk) disable iff (rst)
    !device_wide_clear_n |=> latch_a.q == '0 && latch_b.q == '0)
    else $error("device-wide clear missed a latch");
  a_write_while_full: assert property (@(posedge clk) disable iff (rst)
    write_clock_enable && write_strobe && !can_write && !fifo_link.clear && !fifo_link.rewind
    && !fifo_link.out_ready |=> fifo_link.count == $past(fifo_link.count))
    else $error("write accepted while full");
  c_fifo_fills: cover property (@(posedge clk) disable iff (rst) full_flag);
  c_rewind_replay: cover property (@(posedge clk) disable iff (rst)
    fifo_link.rewind && fifo_link.count == '0 ##1 fifo_link.count != '0);
  c_read_first: cover property (@(posedge clk) disable iff (rst)
    ram_we && mode == bram_fifo_pkg::WRITE_READ_FIRST);
endmodule

// ### pkg/bram_fifo_defines.svh
// Register offsets, field positions and reset values of the block RAM FIFO.
//
// Operation
// - Normal write mode: port output shows stored data on reads only, never during writes.
// - Write-through mode: port output shows a copy of the data being written.
// - Read-before-write mode: port output shows old word contents while the new is written.
// - FIFO has write port and independent read port, each with enable and strobe.
// - FIFO builds full, near-full, near-empty and empty flags itself.
// - Full and near-full flags are registered on the write side clock; here they are registered on the single clk that serves both sides.
// - Empty and near-empty flags are registered on the read side clock; here they are registered on the single clk that serves both sides.
// - Full threshold 1..2^N-1; near thresholds 1..full-1; empty fixed at zero.
// - FIFO clear resets both pointers and returns all four flags to reset state.
// - Read pointer rewind resets only the read pointer so held data is replayed.
// - Each port's output latch clears synchronously or asynchronously by configuration.
// - Port A local clear resets only port A latch; port B likewise.
// - Device-wide clear resets the output latches of both ports together.
`ifndef BRAM_FIFO_DEFINES_SVH
`define BRAM_FIFO_DEFINES_SVH

// ****************************************************************
// Register byte offsets.
// ****************************************************************
`define REG_CTRL 6'h00
`define REG_FULL_THR 6'h04
`define REG_NEAR_FULL_THR 6'h08
`define REG_NEAR_EMPTY_THR 6'h0c
`define REG_STATUS 6'h10
`define REG_RAM_ADDR 6'h14
`define REG_RAM_DATA 6'h18
`define REG_RAM_CMD 6'h1c

// ****************************************************************
// Field positions and reset values.
// ****************************************************************
`define CTRL_MODE_LSB 0
`define CTRL_CLEAR_BIT 2
`define CTRL_REWIND_BIT 3
`define RAM_CMD_READ_BIT 0
`define STATUS_COUNT_LSB 4
`define RST_FULL_THR 4'h7
`define RST_NEAR_FULL_THR 4'h6
`define RST_NEAR_EMPTY_THR 4'h1
`define EMPTY_THR 4'h0

`endif

// ### pkg/bram_fifo_pkg.sv
// Types shared by the block RAM FIFO modules.
package bram_fifo_pkg;

  // Write behaviour of the random access port.
  typedef enum logic [1:0] {
    WRITE_NORMAL = 2'h0,
    WRITE_THROUGH = 2'h1,
    WRITE_READ_FIRST = 2'h2
  } write_mode_e;

  // Bus slave handshake states.
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_e;

endpackage

// ### pkg/bram_fifo_if.sv
// Interfaces between the top module, its FIFO store and its output latches.
`timescale 1ns/100ps

// ****************************************************************
// FIFO store connection.
// ****************************************************************
interface fifo_store_if #(parameter int WIDTH = 8, parameter int ADDR_W = 3);
  logic clear;
  logic rewind;
  logic in_valid;
  logic in_ready;
  logic [WIDTH-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [WIDTH-1:0] out_data;
  logic [ADDR_W:0] count;
  modport owner(output clear, rewind, in_valid, in_data, out_ready,
                input in_ready, out_valid, out_data, count);
  modport store(input clear, rewind, in_valid, in_data, out_ready,
                output in_ready, out_valid, out_data, count);
endinterface

// ****************************************************************
// Output latch connection.
// ****************************************************************
interface out_latch_if #(parameter int WIDTH = 8);
  logic load;
  logic [WIDTH-1:0] d;
  logic [WIDTH-1:0] q;
  logic local_clear;
  logic global_clear_n;
  modport owner(output load, d, local_clear, global_clear_n, input q);
  modport latch(input load, d, local_clear, global_clear_n, output q);
endinterface

// ### src/fifo_store.sv
// Circular FIFO store with clear, read pointer rewind and valid/ready on both sides.
`timescale 1ns/100ps

module fifo_store #(
  parameter int WIDTH = 8,
  parameter int ADDR_W = 3
)(
  input wire logic clk,
  input wire logic rst,
  fifo_store_if.store fs
);
  localparam int DEPTH = 1 << ADDR_W;

  // ****************************************************************
  // Storage and pointers.
  // ****************************************************************
  logic [WIDTH-1:0] mem [DEPTH];
  logic [ADDR_W:0] wr_ptr;
  logic [ADDR_W:0] rd_ptr;
  logic [ADDR_W:0] mark;
  logic [ADDR_W:0] next_wr_ptr;
  logic [ADDR_W:0] next_rd_ptr;
  logic [ADDR_W:0] next_mark;
  logic push;
  logic pop;

  generate
    if (WIDTH < 1 || ADDR_W < 1 || ADDR_W > 8)
    begin : g_check
      $error("fifo_store: unsupported WIDTH or ADDR_W");
    end
  endgenerate

  // Space counts from the rewind mark so replayable words are never overwritten.
  assign fs.count = wr_ptr - rd_ptr;
  assign fs.in_ready = (ADDR_W + 1)'(wr_ptr - mark) < (ADDR_W + 1)'(DEPTH);
  assign fs.out_valid = wr_ptr != rd_ptr;
  assign fs.out_data = mem[rd_ptr[ADDR_W-1:0]];
  assign push = fs.in_valid & fs.in_ready;
  assign pop = fs.out_valid & fs.out_ready;

  // Pointer next values; clear beats rewind, rewind beats a read.
  always_comb
  begin
    next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
    if (fs.rewind)
    begin
      next_rd_ptr = mark;
    end
    next_mark = (next_rd_ptr == next_wr_ptr) ? next_rd_ptr : mark;
    if (fs.clear)
    begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
      next_mark = '0;
    end
  end

  // Pointer registers.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      mark <= '0;
    end
    else
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      mark <= next_mark;
    end
  end

  // Word storage written on each accepted push.
  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr[ADDR_W-1:0]] <= fs.in_data;
    end
  end

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  a_refused_write: assert property (@(posedge clk) disable iff (rst)
    fs.in_valid && !fs.in_ready && !fs.clear |=> $stable(wr_ptr))
    else $error("write accepted while no space");
  a_rewind_target: assert property (@(posedge clk) disable iff (rst)
    fs.rewind && !fs.clear |=> rd_ptr == $past(mark))
    else $error("rewind did not return to mark");
  a_clear_empties: assert property (@(posedge clk) disable iff (rst)
    fs.clear |=> wr_ptr == '0 && rd_ptr == '0 && !fs.out_valid)
    else $error("clear did not empty the store");
endmodule

// ### src/out_latch.sv
// Port output data latch with a local clear and a device-wide clear.
`timescale 1ns/100ps

module out_latch #(
  parameter bit ASYNC_CLEAR = 1'b0
)(
  input wire logic clk,
  input wire logic rst,
  out_latch_if.latch lp
);
  logic [$bits(lp.d)-1:0] next_q;
  logic clear_now;

  // Either clear empties the latch; otherwise a load captures new data.
  assign clear_now = lp.local_clear | ~lp.global_clear_n;
  always_comb
  begin
    next_q = lp.load ? lp.d : lp.q;
  end

  // Clear style chosen at build time.
  generate
    if (ASYNC_CLEAR)
    begin : g_async
      always_ff @(posedge clk or posedge clear_now)
      begin
        if (clear_now)
        begin
          lp.q <= '0;
        end
        else if (rst)
        begin
          lp.q <= '0;
        end
        else
        begin
          lp.q <= next_q;
        end
      end
    end
    else
    begin : g_sync
      always_ff @(posedge clk)
      begin
        if (rst || clear_now)
        begin
          lp.q <= '0;
        end
        else
        begin
          lp.q <= next_q;
        end
      end
    end
  endgenerate
endmodule

// ### sim/fabric_model.sv
// Fabric logic that feeds the FIFO write port and pulls from its read port.
`timescale 1ns/100ps

module fabric_model (
  input wire logic clk,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [7:0] word,
  output logic [7:0] write_data,
  output logic write_clock_enable,
  output logic write_strobe,
  output logic read_clock_enable,
  output logic read_strobe
);
  // Strobes follow each request one cycle later; idle data toggles so a stale word never passes.
  always_ff @(posedge clk)
  begin
    write_strobe <= !rst && push;
    write_clock_enable <= !rst && push;
    read_strobe <= !rst && pop;
    read_clock_enable <= !rst && pop;
    write_data <= rst ? 8'h00 : (push ? word : ~write_data);
  end
endmodule

// ### sim/block_ram_fifo_with_port_resets_tb.sv
// Self-checking bench for the block RAM FIFO with its register port.
`timescale 1ns/100ps

module block_ram_fifo_with_port_resets_tb;
  logic clk = 1'b0, rst = 1'b1, read = 1'b0, write = 1'b0, push = 1'b0, pop = 1'b0;
  logic fifo_clear = 1'b0, read_pointer_rewind = 1'b0, port_a_latch_clear = 1'b0;
  logic port_b_latch_clear = 1'b0, device_wide_clear_n = 1'b1, waitrequest;
  logic full_flag, near_full_flag, near_empty_flag, empty_flag;
  logic write_clock_enable, write_strobe, read_clock_enable, read_strobe;
  logic [5:0] address = 6'h00;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] writedata = 32'h0, readdata, q;
  logic [7:0] word = 8'h00, write_data, read_data;
  int mismatches = 0, n_compared = 0;
  // Each row: write flag, address, write data, expected read data.
  logic [70:0] rows [12] = '{{1'h0, 6'h10, 32'h0, 32'h3}, {1'h0, 6'h04, 32'h0, 32'h7},
    {1'h0, 6'h08, 32'h0, 32'h6}, {1'h0, 6'h0c, 32'h0, 32'h1}, {1'h0, 6'h20, 32'h0, 32'h0},
    {1'h1, 6'h04, 32'h8, 32'h0}, {1'h0, 6'h04, 32'h0, 32'h7}, {1'h1, 6'h14, 32'h3, 32'h0},
    {1'h1, 6'h18, 32'h5a, 32'h0}, {1'h0, 6'h18, 32'h0, 32'h0}, {1'h1, 6'h1c, 32'h1, 32'h0},
    {1'h0, 6'h18, 32'h0, 32'h5a}};

  // Free-running 100 MHz clock.
  always #5 clk = ~clk;

  bram_fifo #(.PORT_B_ASYNC(1'b1)) DUT (
    .clk, .rst, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest,
    .write_data, .write_clock_enable, .write_strobe, .read_clock_enable, .read_strobe,
    .read_data, .fifo_clear, .read_pointer_rewind, .port_a_latch_clear, .port_b_latch_clear,
    .device_wide_clear_n, .full_flag, .near_full_flag, .near_empty_flag, .empty_flag
  );
  fabric_model fab (.clk, .rst, .push, .pop, .word, .write_data, .write_clock_enable,
    .write_strobe, .read_clock_enable, .read_strobe);

  task check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus access; the request stands until waitrequest is sampled low.
  task bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !wr;
    write <= wr;
    do
      @(posedge clk);
    while (waitrequest !== 1'b0);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask

  task pushes(input int n, input logic [7:0] base);
    for (int i = 0; i < n; i++)
    begin
      @(posedge clk);
      push <= 1'b1;
      word <= base + 8'(i);
    end
    @(posedge clk);
    push <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Pops one word and looks at the port B latch once it has loaded.
  task pop_chk(input logic [7:0] exp);
    @(posedge clk);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check({24'h0, read_data}, {24'h0, exp});
  endtask

  task final_report;
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // Main sequence: table of register accesses, then the awkward cases.
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check({full_flag, near_full_flag, near_empty_flag, empty_flag}, 32'h3);
    for (int i = 0; i < 12; i++)
    begin
      bus(rows[i][70], rows[i][69:64], rows[i][63:32]);
      if (!rows[i][70]) check(q, rows[i][31:0]);
    end
    bus(1'b1, 6'h00, 32'h1);
    bus(1'b1, 6'h18, 32'h3c);
    bus(1'b0, 6'h18, 32'h0);
    check(q, 32'h3c);
    bus(1'b1, 6'h00, 32'h2);
    bus(1'b1, 6'h18, 32'h77);
    bus(1'b0, 6'h18, 32'h0);
    check(q, 32'h3c);
    $display("test register table done");
    pushes(8, 8'ha0);
    check(full_flag, 32'h1);
    bus(1'b0, 6'h10, 32'h0);
    check(q, 32'h7c);
    for (int i = 0; i < 8; i++)
      pop_chk(8'ha0 + 8'(i < 7 ? i : 6));
    check(empty_flag, 32'h1);
    pushes(3, 8'hb0);
    pop_chk(8'hb0);
    @(posedge clk) read_pointer_rewind <= 1'b1;
    @(posedge clk) read_pointer_rewind <= 1'b0;
    pop_chk(8'hb0);
    @(posedge clk) port_a_latch_clear <= 1'b1;
    @(posedge clk) port_a_latch_clear <= 1'b0;
    bus(1'b0, 6'h18, 32'h0);
    check(q, 32'h0);
    check(read_data, 32'hb0);
    bus(1'b1, 6'h1c, 32'h1);
    @(posedge clk) port_b_latch_clear <= 1'b1;
    @(posedge clk) port_b_latch_clear <= 1'b0;
    bus(1'b0, 6'h18, 32'h0);
    check(q, 32'h77);
    check(read_data, 32'h0);
    pop_chk(8'hb1);
    @(posedge clk) device_wide_clear_n <= 1'b0;
    @(posedge clk) device_wide_clear_n <= 1'b1;
    @(negedge clk);
    check(read_data, 32'h0);
    bus(1'b0, 6'h18, 32'h0);
    check(q, 32'h0);
    @(posedge clk) fifo_clear <= 1'b1;
    @(posedge clk) fifo_clear <= 1'b0;
    bus(1'b0, 6'h10, 32'h0);
    check(q, 32'h3);
    pushes(2, 8'hc0);
    pop_chk(8'hc0);
    bus(1'b1, 6'h00, 32'h8);
    pop_chk(8'hc0);
    bus(1'b1, 6'h00, 32'h4);
    bus(1'b0, 6'h10, 32'h0);
    check(q, 32'h3);
    $display("test stream and clears done");
    final_report;
  end

  // Cuts a hang short well beyond the roughly 160 cycles the tests need.
  initial
  begin
    #50000;
    mismatches++;
    $display("FAIL t=%0t watchdog expired", $time);
    final_report;
  end
endmodule
